// file: rtl/pfs_defs.svh
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH
// ==========================================
// Register map (byte addresses, one word each)
`define PFS_ADR_STATUS   8'h00
`define PFS_ADR_LIMIT    8'h04
`define PFS_ADR_CTRL     8'h08
// ==========================================
// Field positions
`define PFS_CTRL_CLEAR   0
`define PFS_ST_OC_CNT    8
`define PFS_ST_UV_CNT    12
// ==========================================
// Reset values
`define PFS_LIMIT_RST    8'h78
// ==========================================
// Temperature thresholds, degrees C
`define PFS_OTP_RISE_C   9'h08c
`define PFS_OTP_FALL_C   9'h080
`define PFS_CLAMP_C      9'h1e7
// ==========================================
// Report levels, millivolts
`define PFS_TEMP_MV0     13'h0258
`define PFS_TEMP_SHIFT   3
`define PFS_CLAMP_MV     12'h190
`define PFS_HIGH_MV      12'hce4
`define PFS_OC_MV        12'h898
`define PFS_OTP_MV       12'h320
`define PFS_ZERO_MV      12'h000
// ==========================================
// Event counting, in PWM cycles
`define PFS_BAD_LIMIT    4'ha
`define PFS_GOOD_LIMIT   2'h3
`endif

// file: rtl/pfs_pkg.sv
package pfs_pkg;
    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } pfs_wb_req_t;
    // Wishbone answer to the master
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } pfs_wb_rsp_t;
    // Pin-side detector levels, asynchronous to the clock
    typedef struct packed {
        logic pwm_high;
        logic pwm_tri;
        logic boot_uv;
        logic hs_short;
        logic drv_uv;
    } pfs_pins_t;
    // Gate drive and report levels
    typedef struct packed {
        logic        hs_gate;
        logic        ls_gate;
        logic        pwm_pull_down;
        logic        temp_fault_pull_down;
        logic [11:0] temp_fault_mv;
        logic        current_force;
        logic [11:0] current_report_mv;
    } pfs_drive_t;
endpackage

// file: rtl/pfs_sync2.sv
`timescale 1ns/10ps
// ==========================================
// Two-stage synchroniser for a vector of levels
module pfs_sync2 #(
    parameter int W = 5
) (
    input  wire logic         clk_sys_in,
    input  wire logic         reset_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } pfs_sync_st_t;
    pfs_sync_st_t st_q;
    pfs_sync_st_t st_d;

    // First stage feeds only the second
    always_comb begin
        st_d.meta   = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;
endmodule

// file: rtl/pfs_event_counter.sv
`timescale 1ns/10ps
`include "pfs_defs.svh"
// ==========================================
// Per-PWM-cycle bad event counter with good-run restart
module pfs_event_counter (
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic       clear_in,
    input  wire logic       strobe_in,
    input  wire logic       bad_in,
    output logic            trip_out,
    output logic      [3:0] count_out
);
    typedef struct packed {
        logic [3:0] bad_cnt;
        logic [1:0] good_cnt;
    } pfs_cnt_st_t;
    pfs_cnt_st_t st_q;
    pfs_cnt_st_t st_d;

    // One evaluation per strobe; a good run of three restarts the count
    always_comb begin
        st_d = st_q;
        if (clear_in) begin
            st_d = '0;
        end else if (strobe_in) begin
            if (bad_in) begin
                st_d.good_cnt = 2'h0;
                if (st_q.bad_cnt != `PFS_BAD_LIMIT) begin
                    st_d.bad_cnt = st_q.bad_cnt + 4'h1;
                end
            end else if (st_q.good_cnt + 2'h1 == `PFS_GOOD_LIMIT) begin
                st_d = '0;
            end else begin
                st_d.good_cnt = st_q.good_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Fires on the strobe that brings the tenth bad cycle
    assign trip_out  = strobe_in && bad_in && !clear_in && (st_q.bad_cnt == `PFS_BAD_LIMIT - 4'h1);
    assign count_out = st_q.bad_cnt;
endmodule

// file: rtl/pfs_supervisor.sv
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "pfs_defs.svh"
// What this block does
// RULE1: Without fault, report temperature as 600 mV plus 8 mV per degree.
// RULE2: Catastrophic fault drives fault output to 3.3 V; non-catastrophic to 0 V.
// RULE3: Below minus 25 degrees the temperature report clamps at 400 mV.
// RULE4: Above 140 degrees raise fault, switch both gates off, ignore PWM.
// RULE5: Hold over-temperature fault high until temperature falls below 128 degrees.
// RULE6: Controller tri-states PWM after seeing a catastrophic fault high.
// RULE7: After over-temperature and PWM tri-state, force current report to 800 mV.
// RULE8: Each cycle compare current to limit, default 120 A; truncate high pulse.
// RULE9: Ten over-current cycles without three good cycles latch over-current fault.
// RULE10: After over-current latch and PWM tri-state, force current report to 2.2 V.
// RULE11: Ten bootstrap under-voltage cycles latch a catastrophic fault.
// RULE12: Three good cycles without bootstrap under-voltage clear its counter.
// RULE13: After bootstrap fault and PWM tri-state, force current report to 0 V.
// RULE14: High-side short drives and latches fault and current report at 3.3 V.
// RULE15: During high-side short, keep following PWM commands.
// RULE16: Controller may then command PWM low to destroy the stage.
// RULE17: Driver-supply under-voltage weakly pulls PWM and fault low, report 0 V.
// RULE18: Latched faults stop PWM response; after tri-state fault output reports temperature.
// RULE19: Driver-supply under-voltage in operation stops switching, both reports at 0 V.
// RULE20: Event counters are evaluated once per PWM period at its rising edge.
module pfs_supervisor
    import pfs_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    input  wire pfs_wb_req_t wb_req_in,
    output pfs_wb_rsp_t      wb_rsp_out,
    input  wire pfs_pins_t   pins_in,
    input  wire logic [8:0]  temp_c_in,
    input  wire logic [7:0]  switch_amps_in,
    output pfs_drive_t       drive_out
);
    // ==========================================
    // Software view
    // Three word registers, byte addressed.
    // Status at 0x00 is read only:
    //   bit 0      too hot, held until below the falling point
    //   bit 1      over-temperature latch
    //   bit 2      over-current latch
    //   bit 3      bootstrap latch
    //   bit 4      high-side short latch
    //   bit 5      driver supply low, live
    //   bit 6      controller tri-stated PWM
    //   bits 11:8  over-current bad count
    //   bits 15:12 bootstrap bad count
    // Limit at 0x04 holds the limit in amps.
    // Only byte lane 0 is honoured.
    // Control at 0x08, write only: bit 0 clears.
    // Other offsets read zero and drop writes,
    // so a stray access never hangs the bus.
    // Ack comes one cycle after the take,
    // and is low in the cycle after that.
    // ==========================================
    // Fault output priority, highest first
    //   driver supply low   0 mV, weak pull
    //   short or too hot    3300 mV
    //   latch, no tri yet   3300 mV
    //   otherwise           temperature code
    // Heat keeps the pin high until below the
    // falling point, even after tri-state.
    // Current report priority, highest first
    //   driver supply low   0 mV
    //   high-side short     3300 mV
    //   over-temperature    800 mV, after tri
    //   over-current        2200 mV, after tri
    //   bootstrap           0 mV, after tri
    // ==========================================
    // Timing and limits
    // Pins take two edges to cross in; the
    // outputs follow one edge later.
    // Temperature and current are on this clock.
    // A window is judged at the next window's
    // rising edge, so trips lag one window.
    // A latch sets one edge after its trip and
    // the report codes one edge after that.
    // A short drives both pins on the edge that
    // first sees it, not one edge later.
    // PWM high and low must each last two clocks
    // or edges are lost in the synchroniser.
    // A heat or short latch set beats a clear in
    // one cycle; a clear cancels a counter trip.
    // A clear while PWM is still tri-stated keeps
    // the tri flag down, so a new fault shows
    // 3300 mV again before its report code.
    // Heat, any latch but the short, and a low
    // driver supply all block switching.

    // ==========================================
    // State
    typedef struct packed {
        logic        pwm_high_prev;
        logic        oc_cut;
        logic        oc_seen;
        logic        uv_seen;
        logic        otp_hot;
        logic        otp_lat;
        logic        oc_lat;
        logic        boot_lat;
        logic        short_lat;
        logic        tri_seen;
        logic [7:0]  oc_limit;
        pfs_wb_rsp_t rsp;
        pfs_drive_t  drv;
    } pfs_sup_st_t;
    pfs_sup_st_t st_q;
    pfs_sup_st_t st_d;

    pfs_pins_t   pins_s;
    logic        cycle_strobe;
    logic        clear_req;
    logic        oc_trip;
    logic        uv_trip;
    logic [3:0]  oc_count;
    logic [3:0]  uv_count;
    logic        wb_take;
    logic        pwm_low;
    logic        blocked;
    logic        latched_cat;
    logic signed [12:0] temp_mv_s;
    logic [11:0] temp_mv;

    // ==========================================
    // Pin inputs cross into the clock domain
    pfs_sync2 #(
        .W ($bits(pfs_pins_t))
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .async_in   (pins_in),
        .sync_out   (pins_s)
    );

    // ==========================================
    // Bus decode helpers
    // Request is taken once; ack drops the cycle after it was given
    assign wb_take   = wb_req_in.cyc && wb_req_in.stb && !st_q.rsp.ack;
    assign clear_req = wb_take && wb_req_in.we && wb_req_in.sel[0] &&
                       (wb_req_in.adr == `PFS_ADR_CTRL) && wb_req_in.dat[`PFS_CTRL_CLEAR];

    // ==========================================
    // PWM cycle framing
    assign cycle_strobe = pins_s.pwm_high && !st_q.pwm_high_prev; // RULE20
    assign pwm_low      = !pins_s.pwm_high && !pins_s.pwm_tri;

    // ==========================================
    // Event counters
    pfs_event_counter u_oc_cnt (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .clear_in   (clear_req),
        .strobe_in  (cycle_strobe),
        .bad_in     (st_q.oc_seen),
        .trip_out   (oc_trip),
        .count_out  (oc_count)
    ); // RULE9

    pfs_event_counter u_uv_cnt (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .clear_in   (clear_req),
        .strobe_in  (cycle_strobe),
        .bad_in     (st_q.uv_seen),
        .trip_out   (uv_trip),
        .count_out  (uv_count)
    ); // RULE11 RULE12

    // ==========================================
    // Temperature code
    // Slope applied as a shift; sign-extended so cold readings stay correct
    assign temp_mv_s = $signed(`PFS_TEMP_MV0) +
                       ($signed({{4{temp_c_in[8]}}, temp_c_in}) <<< `PFS_TEMP_SHIFT); // RULE1
    always_comb begin
        if ($signed(temp_c_in) < $signed(`PFS_CLAMP_C)) begin
            temp_mv = `PFS_CLAMP_MV; // RULE3
        end else begin
            temp_mv = temp_mv_s[11:0];
        end
    end

    // Faults that stop switching
    assign latched_cat = st_q.otp_lat || st_q.oc_lat || st_q.boot_lat;
    assign blocked     = latched_cat || st_q.otp_hot || pins_s.drv_uv; // RULE4 RULE18 RULE19

    // ==========================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.pwm_high_prev = pins_s.pwm_high;

        // Over-temperature with hysteresis
        if ($signed(temp_c_in) > $signed(`PFS_OTP_RISE_C)) begin
            st_d.otp_hot = 1'b1; // RULE4
        end else if ($signed(temp_c_in) < $signed(`PFS_OTP_FALL_C)) begin
            st_d.otp_hot = 1'b0; // RULE5
        end

        // Per-cycle observations restart at each cycle edge
        if (cycle_strobe) begin
            st_d.oc_cut  = 1'b0;
            st_d.oc_seen = 1'b0;
            st_d.uv_seen = pins_s.boot_uv;
        end else if (pins_s.boot_uv) begin
            st_d.uv_seen = 1'b1;
        end
        if (pins_s.pwm_high && (switch_amps_in > st_q.oc_limit)) begin
            st_d.oc_cut  = 1'b1; // RULE8
            st_d.oc_seen = 1'b1;
        end

        // Software clear first, so heat and short sets below win
        if (clear_req) begin
            st_d.otp_lat  = 1'b0;
            st_d.oc_lat   = 1'b0;
            st_d.boot_lat = 1'b0;
            st_d.short_lat = 1'b0;
            st_d.tri_seen = 1'b0;
        end
        if (st_d.otp_hot) begin
            st_d.otp_lat = 1'b1;
        end
        if (oc_trip) begin
            st_d.oc_lat = 1'b1; // RULE9
        end
        if (uv_trip) begin
            st_d.boot_lat = 1'b1; // RULE11
        end
        if (pins_s.hs_short) begin
            st_d.short_lat = 1'b1; // RULE14
        end
        // Controller answers a latched fault by tri-stating PWM
        if (latched_cat && !clear_req && pins_s.pwm_tri) begin
            st_d.tri_seen = 1'b1; // RULE6
        end

        // Gate drive: a high-side short alone does not block
        st_d.drv.hs_gate = pins_s.pwm_high && !st_d.oc_cut && !blocked; // RULE8 RULE15
        st_d.drv.ls_gate = pwm_low && !blocked; // RULE15 RULE16
        st_d.drv.pwm_pull_down = pins_s.drv_uv; // RULE17

        // Fault output priority
        st_d.drv.temp_fault_pull_down = 1'b0;
        if (pins_s.drv_uv) begin
            st_d.drv.temp_fault_mv        = `PFS_ZERO_MV; // RULE2 RULE17
            st_d.drv.temp_fault_pull_down = 1'b1;
        end else if (st_d.short_lat || st_q.otp_hot) begin
            st_d.drv.temp_fault_mv = `PFS_HIGH_MV; // RULE2 RULE5 RULE14
        end else if (latched_cat && !st_q.tri_seen) begin
            st_d.drv.temp_fault_mv = `PFS_HIGH_MV; // RULE2
        end else begin
            st_d.drv.temp_fault_mv = temp_mv; // RULE1 RULE18
        end

        // Phase-specific current report override
        st_d.drv.current_force     = 1'b1;
        st_d.drv.current_report_mv = `PFS_ZERO_MV;
        if (pins_s.drv_uv) begin
            st_d.drv.current_report_mv = `PFS_ZERO_MV; // RULE17 RULE19
        end else if (st_d.short_lat) begin
            st_d.drv.current_report_mv = `PFS_HIGH_MV; // RULE14
        end else if (st_q.tri_seen && st_q.otp_lat) begin
            st_d.drv.current_report_mv = `PFS_OTP_MV; // RULE7
        end else if (st_q.tri_seen && st_q.oc_lat) begin
            st_d.drv.current_report_mv = `PFS_OC_MV; // RULE10
        end else if (st_q.tri_seen && st_q.boot_lat) begin
            st_d.drv.current_report_mv = `PFS_ZERO_MV; // RULE13
        end else begin
            st_d.drv.current_force = 1'b0;
        end

        // Wishbone slave, one wait state, unmapped reads as zero
        st_d.rsp.ack = wb_take;
        st_d.rsp.dat = 32'h0000_0000;
        if (wb_take) begin
            if (wb_req_in.adr == `PFS_ADR_STATUS) begin
                st_d.rsp.dat = {16'h0000, uv_count, oc_count, 1'b0, st_q.tri_seen, pins_s.drv_uv,
                                st_q.short_lat, st_q.boot_lat, st_q.oc_lat, st_q.otp_lat, st_q.otp_hot};
            end else if (wb_req_in.adr == `PFS_ADR_LIMIT) begin
                st_d.rsp.dat = {24'h000000, st_q.oc_limit};
                if (wb_req_in.we && wb_req_in.sel[0]) begin
                    st_d.oc_limit = wb_req_in.dat[7:0];
                end
            end else if (wb_req_in.adr == `PFS_ADR_CTRL) begin
                st_d.rsp.dat = 32'h0000_0000;
            end
        end
    end

    // ==========================================
    // Register everything
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            st_q          <= '0;
            st_q.oc_limit <= `PFS_LIMIT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flip-flops
    assign wb_rsp_out = st_q.rsp;
    assign drive_out  = st_q.drv;
endmodule

// file: verif/pfs_supervisor_asserts.sv
`timescale 1ns/10ps
`include "pfs_defs.svh"
// ==========================================
// Port-level checks of the fault supervisor
module pfs_supervisor_asserts
    import pfs_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    input  wire pfs_wb_req_t wb_req_in,
    input  wire pfs_wb_rsp_t wb_rsp_out,
    input  wire pfs_pins_t   pins_in,
    input  wire logic [8:0]  temp_c_in,
    input  wire logic [7:0]  switch_amps_in,
    input  wire pfs_drive_t  drive_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    int          t;
    logic [11:0] lin_mv;
    logic        quiet;
    logic        flag_hi;
    logic [7:0]  lim_q;
    // ==========================================
    // Helpers
    assign t       = int'($signed(temp_c_in));
    assign lin_mv  = 12'(600 + 8 * t);
    assign quiet   = !pins_in.drv_uv && !pins_in.hs_short;
    assign flag_hi = drive_out.temp_fault_mv == 12'hce4;
    // Shadow of the limit; the write lands at the taking edge
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in)
            lim_q <= `PFS_LIMIT_RST;
        else if (wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && !wb_rsp_out.ack
                 && wb_req_in.adr == `PFS_ADR_LIMIT && wb_req_in.sel[0])
            lim_q <= wb_req_in.dat[7:0];
    end
    // Steady temperature, so either latency of the report is covered
    sequence s_mild;
        quiet && temp_c_in == $past(temp_c_in) && t >= -25 && t <= 127;
    endsequence
    sequence s_cold;
        quiet && temp_c_in == $past(temp_c_in) && t < -25;
    endsequence
    sequence s_hot;
        t > 140 && !pins_in.drv_uv;
    endsequence
    sequence s_warm;
        t >= 128 && t <= 140 && !pins_in.drv_uv;
    endsequence
    // ==========================================
    // Assertions
    a_ack_single: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
        else $error("ack held past one cycle");
    a_ack_prompt: assert property (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack |=> wb_rsp_out.ack)
        else $error("request not answered next cycle");
    a_temp_linear: assert property (s_mild [*3] |=> drive_out.temp_fault_mv == lin_mv || flag_hi)
        else $error("temperature code wrong");
    a_temp_clamp: assert property (s_cold [*3] |=> drive_out.temp_fault_mv == 12'h190 || flag_hi)
        else $error("cold clamp missing");
    a_hot_off: assert property (s_hot [*3] |=> flag_hi && !drive_out.hs_gate && !drive_out.ls_gate)
        else $error("hot stage not shut down");
    a_hot_hold: assert property (s_hot ##1 s_warm [*3] |=> flag_hi)
        else $error("hot flag dropped above falling point");
    a_oc_trunc: assert property ((switch_amps_in > lim_q && pins_in.pwm_high) [*4] |=> !drive_out.hs_gate)
        else $error("high pulse not cut on over-current");
    a_short_flag: assert property ((pins_in.hs_short && !pins_in.drv_uv) [*3] |=> flag_hi
        && drive_out.current_force && drive_out.current_report_mv == 12'hce4)
        else $error("short not flagged");
    a_uv_quiet: assert property (pins_in.drv_uv [*3] |=> drive_out.temp_fault_mv == 12'h000
        && drive_out.temp_fault_pull_down && drive_out.pwm_pull_down && drive_out.current_force
        && drive_out.current_report_mv == 12'h000 && !drive_out.hs_gate && !drive_out.ls_gate)
        else $error("supply droop not quiet");
endmodule
bind pfs_supervisor pfs_supervisor_asserts pfs_supervisor_asserts_inst (
    .clk_sys_in     (clk_sys_in),
    .reset_n_in     (reset_n_in),
    .wb_req_in      (wb_req_in),
    .wb_rsp_out     (wb_rsp_out),
    .pins_in        (pins_in),
    .temp_c_in      (temp_c_in),
    .switch_amps_in (switch_amps_in),
    .drive_out      (drive_out)
);

// file: verif/pfs_ctrl_model.sv
`timescale 1ns/10ps
// ==========================================
// Controller stand-in: PWM source that reacts to the fault flag
module pfs_ctrl_model
    import pfs_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic       run_in,
    input  wire logic       short_low_in,
    input  wire pfs_drive_t drive_in,
    output logic            pwm_high_out,
    output logic            pwm_tri_out,
    output logic            start_out
);
    logic [2:0] ph_q;
    logic       tri_q;
    logic       low_q;
    logic       shorted;
    // High for the first half of an eight-cycle period
    assign pwm_high_out = run_in && !tri_q && !low_q && !ph_q[2];
    assign pwm_tri_out  = tri_q;
    assign start_out    = run_in && !tri_q && !low_q && ph_q == 3'h7;
    assign shorted      = drive_in.current_force && drive_in.current_report_mv == 12'hce4;
    // The flag is judged only once it is raised; release needs run low
    always @(posedge clk_sys_in) begin
        if (!reset_n_in || !run_in) begin
            ph_q  <= 3'h0;
            tri_q <= 1'b0;
            low_q <= 1'b0;
        end else begin
            ph_q <= ph_q + 3'h1;
            if (drive_in.temp_fault_mv == 12'hce4 && short_low_in && shorted)
                low_q <= 1'b1;
            else if (drive_in.temp_fault_mv == 12'hce4)
                tri_q <= 1'b1;
        end
    end
endmodule

// file: verif/pfs_supervisor_bench.sv
`timescale 1ns/10ps
`include "pfs_defs.svh"
// ==========================================
// Self-checking bench for the fault supervisor
module pfs_supervisor_bench
    import pfs_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    pfs_wb_req_t req = '0;
    pfs_wb_rsp_t rsp;
    pfs_pins_t   pins;
    pfs_drive_t  drv;
    logic [8:0]  temp = 9'h019;
    logic [7:0]  amps = 8'h00;
    logic        run = 1'b0;
    logic        hlow = 1'b0;
    logic        buv = 1'b0;
    logic        hshort = 1'b0;
    logic        duv = 1'b0;
    logic        ph, pt, start;
    logic [31:0] rd;
    int          n_errors = 0;
    int          cmp_count = 0;
    // 20 MHz clock
    always #25 clk = ~clk;
    assign pins = '{pwm_high: ph, pwm_tri: pt, boot_uv: buv, hs_short: hshort, drv_uv: duv};
    pfs_supervisor pfs_supervisor_inst (.clk_sys_in(clk), .reset_n_in(reset_n), .wb_req_in(req),
        .wb_rsp_out(rsp), .pins_in(pins), .temp_c_in(temp), .switch_amps_in(amps), .drive_out(drv));
    pfs_ctrl_model pfs_ctrl_model_inst (.clk_sys_in(clk), .reset_n_in(reset_n), .run_in(run),
        .short_low_in(hlow), .drive_in(drv), .pwm_high_out(ph), .pwm_tri_out(pt), .start_out(start));
    // ==========================================
    // Reference model and helpers
    function automatic int exp_t(int t);
        return (t < -25) ? 400 : 600 + 8 * t;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
            n_errors++;
        end
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic hang();
        n_errors++;
        end_sim();
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // Classic cycle; ack is read before the edge's own updates land
    task automatic wb(logic we, logic [7:0] adr, logic [31:0] d);
        int k = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
        do begin
            @(posedge clk);
            k++;
        end while (rsp.ack !== 1'b1 && k < 20);
        if (k >= 20)
            hang();
        rd = rsp.dat;
        req <= '0;
        @(posedge clk);
    endtask
    // Set current and boot level at each of n PWM rises
    task automatic win(int n, logic [7:0] a, logic b);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (start !== 1'b1 && k < 20);
            if (k >= 20)
                hang();
            amps <= a;
            buv  <= b;
        end
    endtask
    // Runs broken by one good window keep counting; three good restart
    task automatic trip(logic [7:0] a, logic [7:0] g, logic b);
        win(9, a, b);
        win(3, g, 1'b0);
        win(9, a, b);
        win(1, g, 1'b0);
        tick(6);
        chk("no trip", drv.temp_fault_mv, 32'h320);
        win(1, a, b);
        win(1, g, 1'b0);
        tick(16);
    endtask
    task automatic rearm();
        run <= 1'b0;
        wb(1'b1, `PFS_ADR_CTRL, 32'h1);
        run <= 1'b1;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        int tc;
        logic [7:0] lim;
        void'($urandom(32'h19af2ccf));
        tick(8);
        reset_n <= 1'b1;
        @(posedge clk);
        wb(1'b0, `PFS_ADR_LIMIT, 32'h0);
        chk("limit", rd, 32'h78);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0);
        for (int i = 0; i < 12; i++) begin
            tc = (i < 2) ? i - 26 : int'($urandom_range(167)) - 40;
            temp <= tc[8:0];
            tick(4);
            chk("temp", drv.temp_fault_mv, exp_t(tc));
        end
        run <= 1'b1;
        temp <= 9'h08d;
        tick(4);
        chk("hot", {drv.hs_gate, drv.ls_gate, drv.temp_fault_mv}, {2'b00, 12'hce4});
        temp <= 9'h080;
        tick(6);
        chk("hold", drv.temp_fault_mv, 32'hce4);
        temp <= 9'h019;
        tick(6);
        chk("otp id", {drv.current_force, drv.current_report_mv, drv.temp_fault_mv}, 25'h1320320);
        rearm();
        lim = 8'(40 + $urandom_range(59));
        wb(1'b1, `PFS_ADR_LIMIT, {24'h0, lim});
        trip(lim + 8'h01, lim, 1'b0);
        chk("oc id", {drv.current_force, drv.current_report_mv, drv.temp_fault_mv}, 25'h1898320);
        wb(1'b0, `PFS_ADR_STATUS, 32'h0);
        chk("oc latch", rd[3:2], 32'h1);
        rearm();
        trip(8'h00, 8'h00, 1'b1);
        chk("boot id", {drv.current_force, drv.current_report_mv, drv.temp_fault_mv}, 25'h1000320);
        rearm();
        hlow <= 1'b1;
        hshort <= 1'b1;
        tick(5);
        chk("short", {drv.current_force, drv.current_report_mv, drv.temp_fault_mv}, 25'h1ce4ce4);
        hshort <= 1'b0;
        tick(8);
        chk("short low", {drv.hs_gate, drv.ls_gate, drv.temp_fault_mv}, {2'b01, 12'hce4});
        duv <= 1'b1;
        tick(5);
        chk("droop", {drv.pwm_pull_down, drv.temp_fault_pull_down, drv.current_force, drv.current_report_mv,
            drv.temp_fault_mv, drv.hs_gate, drv.ls_gate}, {3'b111, 24'h0, 2'b00});
        end_sim();
    end
endmodule
